// ===== hw/fdac_pkg.sv
package fdac_pkg;

  // conversion timing: longest conversion time, rounded down to whole clocks
  localparam int CONV_TIME_NS  = 10000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_CYCLES   = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;

  // register map, byte addresses of aligned 32-bit words
  localparam int            ADDR_W     = 5;
  localparam logic [4:0]    OFS_DATA0  = 5'h00;
  localparam logic [4:0]    OFS_DATA1  = 5'h04;
  localparam logic [4:0]    OFS_DATA2  = 5'h08;
  localparam logic [4:0]    OFS_DATA3  = 5'h0c;
  localparam logic [4:0]    OFS_CTRL01 = 5'h10;
  localparam logic [4:0]    OFS_CTRL23 = 5'h14;
  localparam logic [4:0]    OFS_STOP   = 5'h18;
  localparam logic [4:0]    OFS_STATUS = 5'h1c;

  // pair control register fields
  localparam int            OE_HI_BIT  = 7;
  localparam int            OE_LO_BIT  = 6;
  localparam int            COUPLE_BIT = 5;
  localparam logic [7:0]    RSVD_BITS  = 8'h1f;
  localparam logic          CTRL_RESET = 1'b0;

  // data, module stop and status fields
  localparam logic [7:0]    DATA_RESET = 8'h00;
  localparam int            STOP_BIT   = 0;
  localparam logic          STOP_RESET = 1'b1;
  localparam int            BUSY_LSB   = 0;
  localparam int            VALID_LSB  = 4;

  // per-channel conversion state
  typedef enum logic [1:0]
  {
    CH_OFF  = 2'b00,
    CH_CONV = 2'b01,
    CH_SHOW = 2'b10
  } fdac_ch_e;

endpackage

// ===== hw/fdac_chan.sv
`timescale 1ns/1ps

module fdac_chan
#(
  parameter int CONV_CYCLES = fdac_pkg::CONV_CYCLES
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // control from the register file, hold from chip standby
  input  wire logic       hold,
  input  wire logic       conv_en,
  input  wire logic       start,
  input  wire logic [7:0] code_in,
  // converter side
  output logic      [7:0] code_out,
  output logic            busy,
  output logic            valid
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CONV_CYCLES - 1);

  fdac_pkg::fdac_ch_e  state_r;
  logic       [CW-1:0] cnt_r;
  logic          [7:0] code_r;
  logic          [7:0] pend_r;

  // conversion sequencer; frozen in standby so the output is held
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= fdac_pkg::CH_OFF;
      cnt_r   <= '0;
      pend_r  <= fdac_pkg::DATA_RESET;
    end
    else if (!hold)
    begin
      if (!conv_en)
        state_r <= fdac_pkg::CH_OFF;
      else if (start)
      begin
        state_r <= fdac_pkg::CH_CONV;
        cnt_r   <= LOAD;
        pend_r  <= code_in;
      end
      else
      begin
        unique case (state_r)
          fdac_pkg::CH_OFF:  state_r <= fdac_pkg::CH_OFF;
          fdac_pkg::CH_CONV:
          begin
            if (cnt_r == '0)
              state_r <= fdac_pkg::CH_SHOW;
            else
              cnt_r <= cnt_r - CW'(1);
          end
          fdac_pkg::CH_SHOW: state_r <= fdac_pkg::CH_SHOW;
          default:           state_r <= fdac_pkg::CH_OFF;
        endcase
      end
    end
  end

  // result and validity; old result stays up while a new one converts
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      code_r <= fdac_pkg::DATA_RESET;
      valid  <= 1'b0;
    end
    else if (!hold)
    begin
      if (!conv_en)
        valid <= 1'b0;
      else if (!start && state_r == fdac_pkg::CH_CONV && cnt_r == '0)
      begin
        code_r <= pend_r;
        valid  <= 1'b1;
      end
    end
  end

  assign code_out = code_r;
  assign busy     = (state_r == fdac_pkg::CH_CONV);

endmodule

// ===== hw/fdac_top.sv
// Overview of operation
// - bit 7 upper control enables channel 3
// - bit 6 upper control enables channel 2
// - coupling clear: channels 2, 3 independent
// - coupling set: low enable converts both; the code also converts both when only the high enable is set
// - output drive follows own enable only
// - bits 4..0 read one, ignore writes
// - uncoupled ch3 enable leaves ch2 off
// - four independent conversion channels
// - enable set starts conversion, result after time
// - result held until rewrite or disable
// - data write while enabled restarts conversion
// - enable cleared disables analog output
// - full 8-bit code passed unaltered
// - module stop control, stopped at reset
// - registers other than module stop reachable only when not stopped
// - standby holds enabled channel output
// - four 8-bit read/write data registers
// - lower control mirrors upper for 0,1
`timescale 1ns/1ps

module fdac_top
#(
  parameter int CONV_CYCLES = fdac_pkg::CONV_CYCLES
)
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // chip power state
  input  wire logic        sw_standby,
  // converter outputs
  output logic      [7:0]  analog_out_ch0,
  output logic      [7:0]  analog_out_ch1,
  output logic      [7:0]  analog_out_ch2,
  output logic      [7:0]  analog_out_ch3,
  output logic             out_drive_ch0,
  output logic             out_drive_ch1,
  output logic             out_drive_ch2,
  output logic             out_drive_ch3,
  output logic             analog_active
);

  // pair conversion enables {hi, lo} from enables and coupling
  function automatic logic [1:0] pair_conv(input logic oe_hi, input logic oe_lo, input logic couple);
    logic [1:0] r;
    r = 2'b00;
    if (!couple)
      r = {oe_hi, oe_lo};
    else if (oe_lo || oe_hi)
      r = 2'b11;
    return r;
  endfunction

  // pair control read image, reserved bits forced high
  function automatic logic [7:0] ctrl_image(input logic oe_hi, input logic oe_lo, input logic couple);
    logic [7:0] r;
    r = fdac_pkg::RSVD_BITS;
    r[fdac_pkg::OE_HI_BIT]  = oe_hi;
    r[fdac_pkg::OE_LO_BIT]  = oe_lo;
    r[fdac_pkg::COUPLE_BIT] = couple;
    return r;
  endfunction

  // register state
  logic [7:0]  data_r [4];
  logic [3:0]  oe_r;
  logic        couple_lo_r;
  logic        couple_hi_r;
  logic        stop_r;

  // bus handshake state
  logic [31:0] readdata_r;
  logic        waitrequest_r;
  logic        commit;
  logic        wr_ok;
  logic        rd_ok;

  // conversion control
  logic [3:0]  conv_en;
  logic [3:0]  conv_en_q_r;
  logic [3:0]  wr_start_r;
  logic [3:0]  wr_start_nxt;
  logic [3:0]  start;
  logic [3:0]  busy_w;
  logic [3:0]  valid_w;
  logic [7:0]  code_w [4];

  // output stage
  logic [7:0]  out_r [4];
  logic [3:0]  drive_r;
  logic        active_r;

  // a request completes at the edge where waitrequest is seen low
  assign commit = (avs_read || avs_write) && !waitrequest_r;
  assign wr_ok  = commit && avs_write && avs_byteenable[0];
  assign rd_ok  = (avs_read || avs_write) && waitrequest_r;

  // one wait cycle per access, then a single answer cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      waitrequest_r <= 1'b1;
    else if (rd_ok)
      waitrequest_r <= 1'b0;
    else
      waitrequest_r <= 1'b1;
  end

  // read data captured during the wait cycle; stopped module reads zero except the stop register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      readdata_r <= 32'h0000_0000;
    else if (rd_ok)
    begin
      readdata_r <= 32'h0000_0000;
      if (avs_read)
      begin
        if (avs_address == fdac_pkg::OFS_STOP)
          readdata_r[fdac_pkg::STOP_BIT] <= stop_r;
        else if (!stop_r)
        begin
          unique case (avs_address)
            fdac_pkg::OFS_DATA0:  readdata_r[7:0] <= data_r[0];
            fdac_pkg::OFS_DATA1:  readdata_r[7:0] <= data_r[1];
            fdac_pkg::OFS_DATA2:  readdata_r[7:0] <= data_r[2];
            fdac_pkg::OFS_DATA3:  readdata_r[7:0] <= data_r[3];
            fdac_pkg::OFS_CTRL01: readdata_r[7:0] <= ctrl_image(oe_r[1], oe_r[0], couple_lo_r);
            fdac_pkg::OFS_CTRL23: readdata_r[7:0] <= ctrl_image(oe_r[3], oe_r[2], couple_hi_r);
            fdac_pkg::OFS_STATUS:
            begin
              readdata_r[fdac_pkg::BUSY_LSB +: 4]  <= busy_w;
              readdata_r[fdac_pkg::VALID_LSB +: 4] <= valid_w;
            end
            default:              readdata_r      <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // module stop control, reachable at any time
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      stop_r <= fdac_pkg::STOP_RESET;
    else if (wr_ok && avs_address == fdac_pkg::OFS_STOP)
      stop_r <= avs_writedata[fdac_pkg::STOP_BIT];
  end

  // data registers, only written while the module runs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        data_r[i] <= fdac_pkg::DATA_RESET;
    end
    else if (wr_ok && !stop_r)
    begin
      for (int i = 0; i < 4; i++)
        if (avs_address == fdac_pkg::OFS_DATA0 + 5'(4 * i))
          data_r[i] <= avs_writedata[7:0];
    end
  end

  // pair control registers; reserved bits are never stored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      oe_r        <= {4{fdac_pkg::CTRL_RESET}};
      couple_lo_r <= fdac_pkg::CTRL_RESET;
      couple_hi_r <= fdac_pkg::CTRL_RESET;
    end
    else if (wr_ok && !stop_r)
    begin
      if (avs_address == fdac_pkg::OFS_CTRL01)
      begin
        oe_r[1]     <= avs_writedata[fdac_pkg::OE_HI_BIT];
        oe_r[0]     <= avs_writedata[fdac_pkg::OE_LO_BIT];
        couple_lo_r <= avs_writedata[fdac_pkg::COUPLE_BIT];
      end
      if (avs_address == fdac_pkg::OFS_CTRL23)
      begin
        oe_r[3]     <= avs_writedata[fdac_pkg::OE_HI_BIT];
        oe_r[2]     <= avs_writedata[fdac_pkg::OE_LO_BIT];
        couple_hi_r <= avs_writedata[fdac_pkg::COUPLE_BIT];
      end
    end
  end

  // effective conversion enables; a stopped module converts nothing
  always_comb
  begin
    conv_en = {pair_conv(oe_r[3], oe_r[2], couple_hi_r), pair_conv(oe_r[1], oe_r[0], couple_lo_r)};
    if (stop_r)
      conv_en = 4'h0;
  end

  // data rewrites on an enabled channel request a fresh conversion
  always_comb
  begin
    wr_start_nxt = 4'h0;
    for (int i = 0; i < 4; i++)
      if (wr_ok && !stop_r && conv_en[i] && avs_address == fdac_pkg::OFS_DATA0 + 5'(4 * i))
        wr_start_nxt[i] = 1'b1;
  end

  // start pulses held over standby so none is lost
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_start_r  <= 4'h0;
      conv_en_q_r <= 4'h0;
    end
    else if (!sw_standby)
    begin
      wr_start_r  <= wr_start_nxt;
      conv_en_q_r <= conv_en;
    end
    else
      wr_start_r <= wr_start_r | wr_start_nxt;
  end

  // a rising enable or a rewrite both start the channel
  assign start = (conv_en & ~conv_en_q_r) | wr_start_r;

  // four converters, each with its own sequencer
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    fdac_chan
    #(
      .CONV_CYCLES (CONV_CYCLES)
    )
    u_chan
    (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .hold     (sw_standby),
      .conv_en  (conv_en[g]),
      .start    (start[g]),
      .code_in  (data_r[g]),
      .code_out (code_w[g]),
      .busy     (busy_w[g]),
      .valid    (valid_w[g])
    );
  end

  // output stage; drive follows the channel's own enable only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        out_r[i] <= fdac_pkg::DATA_RESET;
      drive_r <= 4'h0;
    end
    else if (!sw_standby)
    begin
      for (int i = 0; i < 4; i++)
      begin
        out_r[i]   <= code_w[i];
        drive_r[i] <= oe_r[i] && valid_w[i] && !stop_r;
      end
    end
  end

  // analog supply stays up while any channel converts or drives
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      active_r <= 1'b0;
    else if (!sw_standby)
      active_r <= |conv_en;
  end

  // bus and converter ports
  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign analog_out_ch0  = out_r[0];
  assign analog_out_ch1  = out_r[1];
  assign analog_out_ch2  = out_r[2];
  assign analog_out_ch3  = out_r[3];
  assign out_drive_ch0   = drive_r[0];
  assign out_drive_ch1   = drive_r[1];
  assign out_drive_ch2   = drive_r[2];
  assign out_drive_ch3   = drive_r[3];
  assign analog_active   = active_r;

endmodule

// ===== tb/fdac_monitor.sv
`timescale 1ns/1ps

module fdac_monitor
#(
  parameter int CONV_CYCLES = 4
)
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // power and outputs
  input wire logic        sw_standby,
  input wire logic [7:0]  analog_out_ch3,
  input wire logic        out_drive_ch0,
  input wire logic        out_drive_ch3
);
  logic ctl01_wr;

  // lower control write committed this cycle
  assign ctl01_wr = avs_write && !avs_waitrequest && avs_address == fdac_pkg::OFS_CTRL01;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // bus handshake
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not after one wait cycle");
  answer_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // control fields and outputs
  reserved_ones_a: assert property (avs_read && !avs_waitrequest && avs_address == fdac_pkg::OFS_CTRL23 &&
    avs_readdata != 32'h0 |-> avs_readdata[4:0] == 5'h1f) else $error("reserved bits not one");
  standby_hold_a: assert property (sw_standby |=> $stable(analog_out_ch3) && $stable(out_drive_ch3))
    else $error("output moved in standby");
  disable_drop_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && !sw_standby &&
    avs_address == fdac_pkg::OFS_CTRL23 && !avs_writedata[7] |=> ##1 !out_drive_ch3) else $error("drive stayed");
  drive_delay_a: assert property ($rose(out_drive_ch0) |-> $past(ctl01_wr, CONV_CYCLES + 3))
    else $error("drive rose at wrong time");
endmodule

bind fdac_top fdac_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon
(
  .ref_clk         (ref_clk),
  .rst             (rst),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_byteenable  (avs_byteenable),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .sw_standby      (sw_standby),
  .analog_out_ch3  (analog_out_ch3),
  .out_drive_ch0   (out_drive_ch0),
  .out_drive_ch3   (out_drive_ch3)
);

// ===== tb/fdac_top_tb.sv
`timescale 1ns/1ps

module fdac_top_tb;
  localparam int CC = 4;
  logic        ref_clk        = 1'b0;
  logic        rst            = 1'b1;
  logic [4:0]  avs_address    = 5'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        sw_standby     = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  aout [4];
  logic [3:0]  drv;
  logic        analog_active;
  logic [7:0]  rd;
  int          errors         = 0;
  int          comparisons    = 0;
  int          cycles         = 0;

  fdac_top #(.CONV_CYCLES(CC)) DUT
  (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sw_standby(sw_standby),
    .analog_out_ch0(aout[0]), .analog_out_ch1(aout[1]), .analog_out_ch2(aout[2]),
    .analog_out_ch3(aout[3]), .out_drive_ch0(drv[0]), .out_drive_ch1(drv[1]),
    .out_drive_ch2(drv[2]), .out_drive_ch3(drv[3]), .analog_active(analog_active)
  );

  // free running clock
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  // hang guard, far above the expected run length
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk(8'(n), 8'h02); // one wait cycle, answer seen on the second edge
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // old code must stand until the exact completion edge
  task automatic conv_wait(input int ch, input logic [7:0] old, input logic [7:0] code);
    repeat (CC + 1) @(posedge ref_clk);
    #1;
    chk(aout[ch], old);
    @(posedge ref_clk);
    #1;
    chk(aout[ch], code);
  endtask

  task automatic t_stop();
    rdc(fdac_pkg::OFS_STOP, 8'h01);
    rdc(fdac_pkg::OFS_CTRL23, 8'h00);
    bus(1'b1, fdac_pkg::OFS_DATA0, 8'h5a);
    bus(1'b1, fdac_pkg::OFS_STOP, 8'h00);
    rdc(fdac_pkg::OFS_DATA0, 8'h00);
  endtask

  task automatic t_regs();
    rdc(fdac_pkg::OFS_CTRL23, 8'h1f);
    rdc(fdac_pkg::OFS_CTRL01, 8'h1f);
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'h1f);
    rdc(fdac_pkg::OFS_CTRL23, 8'h1f);
    for (int i = 0; i < 4; i++)
      bus(1'b1, 5'(i * 4), 8'h81 + 8'(i));
    for (int i = 0; i < 4; i++)
      rdc(5'(i * 4), 8'h81 + 8'(i));
    avs_byteenable <= 4'h0;
    bus(1'b1, fdac_pkg::OFS_DATA1, 8'hee);
    avs_byteenable <= 4'hf;
    rdc(fdac_pkg::OFS_DATA1, 8'h82);
    rdc(5'h02, 8'h00);
  endtask

  task automatic t_ch0();
    bus(1'b1, fdac_pkg::OFS_DATA0, 8'ha5);
    bus(1'b1, fdac_pkg::OFS_CTRL01, 8'h40);
    conv_wait(0, 8'h00, 8'ha5);
    rdc(fdac_pkg::OFS_STATUS, 8'h10);
    repeat (10) @(posedge ref_clk);
    chk(aout[0], 8'ha5);
    bus(1'b1, fdac_pkg::OFS_DATA0, 8'h3c);
    conv_wait(0, 8'ha5, 8'h3c);
    chk({7'h0, drv[0]}, 8'h01);
    bus(1'b1, fdac_pkg::OFS_CTRL01, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h0, drv[0]}, 8'h00);
    chk(aout[0], 8'h3c);
    bus(1'b1, fdac_pkg::OFS_DATA0, 8'h77);
    bus(1'b1, fdac_pkg::OFS_DATA1, 8'h66);
    bus(1'b1, fdac_pkg::OFS_CTRL01, 8'ha0);
    conv_wait(0, 8'h3c, 8'h77);
    chk({7'h0, drv[0]}, 8'h00);
    chk(aout[1], 8'h66);
    chk({7'h0, drv[1]}, 8'h01);
    bus(1'b1, fdac_pkg::OFS_CTRL01, 8'h00);
  endtask

  task automatic t_upper();
    bus(1'b1, fdac_pkg::OFS_DATA2, 8'h11);
    bus(1'b1, fdac_pkg::OFS_DATA3, 8'h22);
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'h80);
    conv_wait(3, 8'h00, 8'h22);
    chk({7'h0, drv[3]}, 8'h01);
    chk({7'h0, drv[2]}, 8'h00);
    chk(aout[2], 8'h00);
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'h00);
    bus(1'b1, fdac_pkg::OFS_DATA3, 8'h33);
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'h60);
    conv_wait(2, 8'h00, 8'h11);
    chk(aout[3], 8'h33);
    chk({7'h0, drv[3]}, 8'h00);
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'h20);
    bus(1'b1, fdac_pkg::OFS_DATA2, 8'h44);
    repeat (CC + 4) @(posedge ref_clk);
    chk(aout[2], 8'h11);
  endtask

  task automatic t_standby();
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'hc0);
    repeat (CC + 4) @(posedge ref_clk);
    chk(aout[2], 8'h44);
    bus(1'b1, fdac_pkg::OFS_DATA3, 8'h55);
    sw_standby <= 1'b1;
    repeat (2 * CC) @(posedge ref_clk);
    chk(aout[3], 8'h33);
    chk({7'h0, analog_active}, 8'h01);
    sw_standby <= 1'b0;
    repeat (CC + 4) @(posedge ref_clk);
    #1;
    chk(aout[3], 8'h55);
    bus(1'b1, fdac_pkg::OFS_CTRL23, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({7'h0, analog_active}, 8'h00);
    bus(1'b1, fdac_pkg::OFS_STOP, 8'h01);
    rdc(fdac_pkg::OFS_DATA0, 8'h00);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_stop();
    t_regs();
    t_ch0();
    t_upper();
    t_standby();
    end_of_test();
  end
endmodule
